/* File: include/flash_ctl_pkg.sv */
// Behaviour
// - Sector erase: 128 bytes primary, 64 secondary
// - Host code 0Dh erases sector unless locked
// - Programming refused when target block locked
// - Host code 07h programs one byte
// - Host code 05h starts row burst program
// - Burst ends: new row, other command, timeout
// - Verify drives flash byte unless locked
// - Done flag low while busy, high after
// - Done flag raised between burst bytes
// - Verify during program shows inverted bit 7
// - Chip erase ignores locks, clears security
// - Block erase picks block from high byte
// - Other block readable by host verify during erase; not during program
// - In-application mode independent of access pin
// - Six commands accepted through command mailbox
// - Address from low and high mailboxes
// - Data mailbox and config status register
// - Command write starts; locked blocks ignored
// - Prescale field sets operation timing
// - Command 00h leaves in-application mode
// - Host mode entered on strobe fall in reset
// - Host commands taken on program strobe fall
// - Erase leaves bytes reading FFh
// - Interrupt on completion when bit 7 set
package flash_ctl_pkg;
  localparam logic [7:0] CFG_OFF   = 8'hF7;
  localparam logic [7:0] DATA_OFF  = 8'hF8;
  localparam logic [7:0] ADRL_OFF  = 8'hF9;
  localparam logic [7:0] ADRH_OFF  = 8'hFA;
  localparam logic [7:0] CMD_OFF   = 8'hFB;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] ERASED    = 8'hFF;
  localparam logic [7:0] GUARD_KEY = 8'h55;
  // Host command codes on the four command pins
  localparam logic [3:0] H_CHIP  = 4'hE;
  localparam logic [3:0] H_BLOCK = 4'hF;
  localparam logic [3:0] H_SECT  = 4'hD;
  localparam logic [3:0] H_BYTE  = 4'h7;
  localparam logic [3:0] H_BURST = 4'h5;
  localparam logic [3:0] H_VERIF = 4'hC;
  // Mailbox command codes, low seven bits
  localparam logic [6:0] M_EXIT  = 7'h00;
  localparam logic [6:0] M_CHIP  = 7'h07;
  localparam logic [6:0] M_BLOCK = 7'h0F;
  localparam logic [6:0] M_SECT  = 7'h0B;
  localparam logic [6:0] M_BYTE  = 7'h0E;
  localparam logic [6:0] M_VERIF = 7'h0C;
  localparam int CFG_BUSY_BIT = 3;
  localparam int CFG_SEC_BIT  = 6;
  localparam int CFG_VIS_BIT  = 7;
  localparam int IRQ_EN_BIT   = 7;
  // Sizes and times
  localparam int SECT_PRI = 128;
  localparam int SECT_SEC = 64;
  localparam logic [3:0] SEC_NIB = 4'hF;
  localparam int CLK_MHZ   = 40;
  localparam int BURST_TO_US = 20;
  localparam int BURST_TO_CYC = BURST_TO_US * CLK_MHZ;
  localparam int PROG_BASE_CYC  = 64;
  localparam int ERASE_BASE_CYC = 512;
endpackage

/* File: logic/flash_array.sv */
`timescale 1ns/1ps
module flash_array #(
  parameter int AW = 16
) (
  input  wire logic          i_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [7:0]    o_rdata
);
  // Writes store the byte as given; the controller ANDs program data with the old byte
  logic [7:0] mem [0:(1<<AW)-1];
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end
  assign o_rdata = mem[i_raddr];
endmodule // flash_array

/* File: logic/flash_program_erase_controller.sv */
`timescale 1ns/1ps
module flash_program_erase_controller #(
  parameter int BURST_TO = flash_ctl_pkg::BURST_TO_CYC
) (
  input  wire logic       I_CLOCK,
  input  wire logic       I_RESETN,
  input  wire logic       i_RESET_PIN,
  input  wire logic       i_PROGRAM_STORE_STROBE_N,
  input  wire logic       i_LATCH_PROGRAM_STROBE_N,
  input  wire logic       i_EXTERNAL_ACCESS_N,
  input  wire logic [3:0] i_CMD_PINS,
  input  wire logic [15:0] i_ADDR_PINS,
  input  wire logic [7:0] i_DATA_PINS,
  input  wire logic [1:0] i_LOCK,
  input  wire logic       i_SFR_WE,
  input  wire logic [7:0] i_SFR_ADDR,
  input  wire logic [7:0] i_SFR_WDATA,
  input  wire logic       i_PC_IN_SEC,
  output logic      [7:0] o_SFR_RDATA,
  output logic      [7:0] o_DATA_PINS,
  output logic            o_DATA_OE,
  output logic            o_DONE_FLAG,
  output logic            o_EXT_IRQ1_N,
  output logic            o_HOST_MODE,
  output logic            o_IN_APP_UPDATE_MODE,
  output logic      [1:0] o_LOCK_CLEARED
);
  //==========================================================
  // Pin synchronisers
  logic [1:0] rst_s, pss_s, lps_s;
  logic [3:0] cmd_s1, cmd_s2;
  logic [15:0] adr_s1, adr_s2;
  logic [7:0] dat_s1, dat_s2;
  logic lps_d;
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_s <= '0; pss_s <= 2'b11; lps_s <= 2'b11; lps_d <= 1'b1;
      cmd_s1 <= '0; cmd_s2 <= '0; adr_s1 <= '0; adr_s2 <= '0;
      dat_s1 <= '0; dat_s2 <= '0;
    end else begin
      rst_s <= {rst_s[0], i_RESET_PIN};
      pss_s <= {pss_s[0], i_PROGRAM_STORE_STROBE_N};
      lps_s <= {lps_s[0], i_LATCH_PROGRAM_STROBE_N};
      lps_d <= lps_s[1];
      cmd_s1 <= i_CMD_PINS; cmd_s2 <= cmd_s1;
      adr_s1 <= i_ADDR_PINS; adr_s2 <= adr_s1;
      dat_s1 <= i_DATA_PINS; dat_s2 <= dat_s1;
    end
  end
  logic pss_d;
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) pss_d <= 1'b1;
    else pss_d <= pss_s[1];
  end
  wire strobe_fall = lps_d & ~lps_s[1];
  wire entry_fall  = rst_s[1] & pss_d & ~pss_s[1];

  //==========================================================
  // Registers and state
  typedef enum {IDLE, ERASE, PROG, BURST_WAIT} st_t;
  st_t st_r, st_nxt;
  logic host_r, host_nxt, iap_r, iap_nxt;
  logic [7:0] cfg_r, cfg_nxt, dat_r, dat_nxt, al_r, al_nxt;
  logic [7:0] ah_r, ah_nxt, cmd_r, cmd_nxt;
  logic [15:0] op_lo_r, op_lo_nxt, op_hi_r, op_hi_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic irq_en_r, irq_en_nxt, irq_n_r, irq_nxt;
  logic done_r, done_nxt;
  logic [1:0] lkc_r, lkc_nxt;
  logic [7:0] rd_r, rd_nxt, pins_r, pins_nxt;
  logic oe_r, oe_nxt;
  logic we;
  logic [15:0] wa;
  logic [7:0] wdat, arr_q;
  logic [15:0] ra;

  flash_array #(.AW(16)) u_arr (
    .i_clk   (I_CLOCK),
    .i_we    (we),
    .i_waddr (wa),
    .i_wdata (wdat),
    .i_raddr (ra),
    .o_rdata (arr_q)
  );

  function automatic logic blk_of(input logic [15:0] a);
    return a[15:12] == flash_ctl_pkg::SEC_NIB;
  endfunction
  // Timing scales with prescale field; longer for larger field
  wire [15:0] prog_cyc = 16'(flash_ctl_pkg::PROG_BASE_CYC
                         * (32'(cfg_r[2:0]) + 1));
  wire [15:0] erase_cyc = 16'(flash_ctl_pkg::ERASE_BASE_CYC
                         * (32'(cfg_r[2:0]) + 1));

  //==========================================================
  // Next-state logic
  always_comb begin
    logic [15:0] a;
    logic lk;
    a = '0;
    lk = 1'b0;
    st_nxt = st_r; host_nxt = host_r; iap_nxt = iap_r;
    cfg_nxt = cfg_r; dat_nxt = dat_r; al_nxt = al_r; ah_nxt = ah_r;
    cmd_nxt = cmd_r; op_lo_nxt = op_lo_r; op_hi_nxt = op_hi_r;
    wd_nxt = wd_r; cnt_nxt = cnt_r; irq_en_nxt = irq_en_r;
    irq_nxt = 1'b0; lkc_nxt = 2'b00; rd_nxt = rd_r;
    pins_nxt = pins_r; oe_nxt = 1'b0;
    we = 1'b0; wa = op_lo_r; wdat = flash_ctl_pkg::ERASED;
    ra = host_r ? adr_s2 : {ah_r, al_r};
    if (entry_fall) host_nxt = 1'b1;
    if (!rst_s[1]) host_nxt = 1'b0;
    // Mailbox writes; busy blocks new commands
    if (i_SFR_WE && !host_r) begin
      unique case (i_SFR_ADDR)
        flash_ctl_pkg::CFG_OFF: cfg_nxt[2:0] = i_SFR_WDATA[2:0];
        flash_ctl_pkg::DATA_OFF: dat_nxt = i_SFR_WDATA;
        flash_ctl_pkg::ADRL_OFF: al_nxt = i_SFR_WDATA;
        flash_ctl_pkg::ADRH_OFF: ah_nxt = i_SFR_WDATA;
        flash_ctl_pkg::CMD_OFF: begin
          cmd_nxt = i_SFR_WDATA;
          iap_nxt = 1'b1;
          a = {ah_r, al_r};
          lk = i_LOCK[blk_of(a)];
          irq_en_nxt = i_SFR_WDATA[flash_ctl_pkg::IRQ_EN_BIT];
          if (i_SFR_WDATA[6:0] == flash_ctl_pkg::M_EXIT) begin
            iap_nxt = 1'b0;
          end else if (st_r == IDLE) begin
            unique case (i_SFR_WDATA[6:0])
              flash_ctl_pkg::M_CHIP: if (dat_r == flash_ctl_pkg::GUARD_KEY)
                begin
                  op_lo_nxt = 16'h0000; op_hi_nxt = 16'hFFFF;
                  lkc_nxt = 2'b11; cnt_nxt = erase_cyc; st_nxt = ERASE;
                end
              flash_ctl_pkg::M_BLOCK: if (!lk &&
                dat_r == flash_ctl_pkg::GUARD_KEY) begin
                op_lo_nxt = blk_of(a) ? 16'hF000 : 16'h0000;
                op_hi_nxt = blk_of(a) ? 16'hFFFF : 16'hEFFF;
                cnt_nxt = erase_cyc; st_nxt = ERASE;
              end
              flash_ctl_pkg::M_SECT: if (!lk) begin
                op_lo_nxt = blk_of(a) ? {a[15:6], 6'h00}
                                      : {a[15:7], 7'h00};
                op_hi_nxt = blk_of(a) ? {a[15:6], 6'h3F}
                                      : {a[15:7], 7'h7F};
                cnt_nxt = erase_cyc; st_nxt = ERASE;
              end
              flash_ctl_pkg::M_BYTE: if (!lk) begin
                op_lo_nxt = a; wd_nxt = dat_r;
                cnt_nxt = prog_cyc; st_nxt = PROG;
              end
              flash_ctl_pkg::M_VERIF: if (!lk) dat_nxt = arr_q;
              default: ;
            endcase
          end
        end
        default: ;
      endcase
    end
    // Host commands on strobe fall
    if (host_r && strobe_fall) begin
      a = adr_s2;
      lk = i_LOCK[blk_of(a)];
      if (st_r == IDLE || st_r == BURST_WAIT) begin
        st_nxt = IDLE;
        unique case (cmd_s2)
          flash_ctl_pkg::H_CHIP: begin
            op_lo_nxt = 16'h0000; op_hi_nxt = 16'hFFFF;
            lkc_nxt = 2'b11; cnt_nxt = erase_cyc; st_nxt = ERASE;
          end
          flash_ctl_pkg::H_BLOCK: if (!lk) begin
            op_lo_nxt = blk_of(a) ? 16'hF000 : 16'h0000;
            op_hi_nxt = blk_of(a) ? 16'hFFFF : 16'hEFFF;
            cnt_nxt = erase_cyc; st_nxt = ERASE;
          end
          flash_ctl_pkg::H_SECT: if (!lk) begin
            op_lo_nxt = blk_of(a) ? {a[15:6], 6'h00}
                                  : {a[15:7], 7'h00};
            op_hi_nxt = blk_of(a) ? {a[15:6], 6'h3F}
                                  : {a[15:7], 7'h7F};
            cnt_nxt = erase_cyc; st_nxt = ERASE;
          end
          flash_ctl_pkg::H_BYTE, flash_ctl_pkg::H_BURST:
            if (!lk) begin
              // A burst byte in another row ends the burst
              if (!(cmd_s2 == flash_ctl_pkg::H_BURST &&
                  st_r == BURST_WAIT &&
                  (blk_of(a) ? a[15:6] != op_hi_r[15:6]
                             : a[15:7] != op_hi_r[15:7]))) begin
                op_lo_nxt = a; wd_nxt = dat_s2;
                op_hi_nxt = (cmd_s2 == flash_ctl_pkg::H_BURST)
                          ? ((st_r == BURST_WAIT) ? op_hi_r : a)
                          : 16'h0000;
                cnt_nxt = prog_cyc; st_nxt = PROG;
              end
            end
          default: ;
        endcase
      end
    end
    // Verify readback, polled bit 7 during programming
    if (host_r && cmd_s2 == flash_ctl_pkg::H_VERIF && lps_s[1]) begin
      oe_nxt = !i_LOCK[blk_of(adr_s2)];
      pins_nxt = (st_r == PROG) ? {~wd_r[7], arr_q[6:0]} : arr_q;
    end
    // Operation sequencing
    unique case (st_r)
      IDLE: ;
      ERASE: begin
        we = 1'b1; wa = op_lo_r;
        if (op_lo_r != op_hi_r) op_lo_nxt = op_lo_r + 16'h0001;
        else if (cnt_r != 16'h0000) cnt_nxt = cnt_r - 16'h0001;
        if (op_lo_r == op_hi_r && cnt_r == 16'h0000) begin
          st_nxt = IDLE; irq_nxt = irq_en_r && iap_r;
        end
      end
      PROG: begin
        if (cnt_r != 16'h0000) cnt_nxt = cnt_r - 16'h0001;
        else begin
          we = 1'b1; wa = op_lo_r; wdat = wd_r & arr_q;
          ra = op_lo_r;
          irq_nxt = irq_en_r && iap_r;
          st_nxt = (host_r && op_hi_r != 16'h0000) ? BURST_WAIT : IDLE;
          cnt_nxt = 16'(BURST_TO);
        end
      end
      BURST_WAIT: begin
        if (cnt_r != 16'h0000) cnt_nxt = cnt_r - 16'h0001;
        else st_nxt = IDLE;
      end
    endcase
    if (st_r == PROG && cnt_r == 16'h0000) ra = op_lo_r;
    cfg_nxt[flash_ctl_pkg::CFG_BUSY_BIT] =
      (st_nxt == ERASE || st_nxt == PROG);
    done_nxt = ~cfg_nxt[flash_ctl_pkg::CFG_BUSY_BIT];
    cfg_nxt[flash_ctl_pkg::CFG_SEC_BIT] = |i_LOCK;
    cfg_nxt[flash_ctl_pkg::CFG_VIS_BIT] = i_PC_IN_SEC;
    unique case (i_SFR_ADDR)
      flash_ctl_pkg::CFG_OFF:  rd_nxt = cfg_r;
      flash_ctl_pkg::DATA_OFF: rd_nxt = dat_r;
      flash_ctl_pkg::ADRL_OFF: rd_nxt = al_r;
      flash_ctl_pkg::ADRH_OFF: rd_nxt = ah_r;
      flash_ctl_pkg::CMD_OFF:  rd_nxt = cmd_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  //==========================================================
  // State registers
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st_r <= IDLE; host_r <= 1'b0; iap_r <= 1'b0;
      cfg_r <= flash_ctl_pkg::RESET_VAL; dat_r <= flash_ctl_pkg::RESET_VAL;
      al_r <= '0; ah_r <= '0; cmd_r <= '0;
      op_lo_r <= '0; op_hi_r <= '0; wd_r <= '0; cnt_r <= '0;
      irq_en_r <= 1'b0; irq_n_r <= 1'b1; lkc_r <= '0; done_r <= 1'b1;
      rd_r <= '0; pins_r <= '0; oe_r <= 1'b0;
    end else begin
      st_r <= st_nxt; host_r <= host_nxt; iap_r <= iap_nxt;
      cfg_r <= cfg_nxt; dat_r <= dat_nxt; al_r <= al_nxt; ah_r <= ah_nxt;
      cmd_r <= cmd_nxt; op_lo_r <= op_lo_nxt; op_hi_r <= op_hi_nxt;
      wd_r <= wd_nxt; cnt_r <= cnt_nxt; irq_en_r <= irq_en_nxt;
      irq_n_r <= ~irq_nxt; lkc_r <= lkc_nxt; done_r <= done_nxt;
      rd_r <= rd_nxt; pins_r <= pins_nxt; oe_r <= oe_nxt;
    end
  end

  assign o_SFR_RDATA          = rd_r;
  assign o_DATA_PINS          = pins_r;
  assign o_DATA_OE            = oe_r;
  assign o_DONE_FLAG          = done_r;
  assign o_EXT_IRQ1_N         = irq_n_r;
  assign o_HOST_MODE          = host_r;
  assign o_IN_APP_UPDATE_MODE = iap_r;
  assign o_LOCK_CLEARED       = lkc_r;

  //==========================================================
  // Checks
  busy_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    st_r == ERASE |=> st_r == ERASE || st_r == IDLE)
    else $error("erase left to wrong state");
  done_low_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    (st_r == PROG || st_r == ERASE) |-> !o_DONE_FLAG)
    else $error("done flag high while programming");
  lock_prog_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    host_r && strobe_fall && cmd_s2 == flash_ctl_pkg::H_BYTE &&
    i_LOCK[blk_of(adr_s2)] && st_r == IDLE |=> st_r == IDLE)
    else $error("locked program started");
  chip_lock_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    host_r && strobe_fall && cmd_s2 == flash_ctl_pkg::H_CHIP &&
    st_r == IDLE |=> st_r == ERASE ##0 lkc_r == 2'b11)
    else $error("chip erase refused");
  exit_iap_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    i_SFR_WE && !host_r && i_SFR_ADDR == flash_ctl_pkg::CMD_OFF &&
    i_SFR_WDATA[6:0] == flash_ctl_pkg::M_EXIT |=> !iap_r)
    else $error("mode not left");
  burst_to_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    st_r == BURST_WAIT && cnt_r == 16'h0000 && !strobe_fall |=> st_r == IDLE)
    else $error("burst outlived timeout");
  erase_ff_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    st_r == ERASE |-> we && wdat == flash_ctl_pkg::ERASED)
    else $error("erase wrote non-FF");
  irq_done_a: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    !o_EXT_IRQ1_N |-> $past(irq_en_r) && $past(st_r) != IDLE)
    else $error("interrupt without completion");
endmodule // flash_program_erase_controller

/* File: tb/host_model.sv */
`timescale 1ns/1ps
// ========================================
// Programmer side of the host-mode pins
module host_model (
  input  wire logic        i_clk,
  input  wire logic        i_done,
  input  wire logic [7:0]  i_dout,
  input  wire logic        i_oe,
  output logic             o_rst_pin,
  output logic             o_pss_n,
  output logic             o_lps_n,
  output logic             o_ea_n,
  output logic [3:0]       o_cmd,
  output logic [15:0]      o_addr,
  output logic [7:0]       o_data
);
  initial begin
    o_rst_pin = 1'b0;
    o_pss_n   = 1'b1;
    o_lps_n   = 1'b1;
    o_ea_n    = 1'b0;
    o_cmd     = 4'h0;
    o_addr    = 16'h0000;
    o_data    = 8'h00;
  end
  task automatic enter();
    @(negedge i_clk);
    o_rst_pin = 1'b1;
    repeat (4) @(negedge i_clk);
    o_pss_n = 1'b0;
    o_ea_n  = 1'b1;
    repeat (6) @(negedge i_clk);
  endtask
  // Pins held past the take edge; data then shows its inverse so a
  // late sample cannot pass by luck
  task automatic pulse(input logic [3:0] c, input logic [15:0] a,
                       input logic [7:0] d, input bit w, output int n);
    n = 0;
    @(negedge i_clk);
    o_cmd  = c;
    o_addr = a;
    o_data = d;
    repeat (2) @(negedge i_clk);
    o_lps_n = 1'b0;
    repeat (4) @(negedge i_clk);
    o_lps_n = 1'b1;
    o_data  = ~d;
    while (w && i_done !== 1'b1 && n < 70000) begin
      n++;
      @(negedge i_clk);
    end
  endtask
  task automatic verify(input logic [15:0] a, output logic [7:0] d,
                        output logic oe);
    @(negedge i_clk);
    o_cmd  = flash_ctl_pkg::H_VERIF;
    o_addr = a;
    o_data = ~o_data;
    repeat (5) @(negedge i_clk);
    // Undriven pins read as the inverse so a stale byte cannot pass
    d  = i_oe ? i_dout : ~i_dout;
    oe = i_oe;
  endtask
endmodule // host_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  localparam logic [3:0] PB = flash_ctl_pkg::H_BYTE;
  localparam logic [3:0] PK = flash_ctl_pkg::H_BURST;
  localparam logic [3:0] PS = flash_ctl_pkg::H_SECT;
  localparam logic [3:0] PF = flash_ctl_pkg::H_BLOCK;
  localparam logic [3:0] PV = flash_ctl_pkg::H_VERIF;
  typedef struct packed {
    logic [3:0]  c;
    logic [15:0] a;
    logic [7:0]  d;
    logic [1:0]  l;
    logic [15:0] va;
    logic [7:0]  e;
  } row_t;
  // Targets are all erased first, so programming never hits a used byte
  localparam row_t ROWS [14] = '{
    '{PB, 16'h0010, 8'h5A, 2'b00, 16'h0010, 8'h5A},
    '{PB, 16'h0090, 8'hA5, 2'b00, 16'h0090, 8'hA5},
    '{PB, 16'hF005, 8'h3C, 2'b00, 16'hF005, 8'h3C},
    '{PB, 16'hF045, 8'hC3, 2'b00, 16'hF045, 8'hC3},
    '{PB, 16'h0020, 8'h11, 2'b01, 16'h0020, 8'hFF},
    '{PB, 16'hF010, 8'h22, 2'b10, 16'hF010, 8'hFF},
    '{PS, 16'h0010, 8'h00, 2'b00, 16'h0010, 8'hFF},
    '{PV, 16'h0000, 8'h00, 2'b00, 16'h0090, 8'hA5},
    '{PS, 16'hF005, 8'h00, 2'b00, 16'hF045, 8'hC3},
    '{PS, 16'hF045, 8'h00, 2'b10, 16'hF045, 8'hC3},
    '{PV, 16'h0000, 8'h00, 2'b00, 16'hF005, 8'hFF},
    '{PF, 16'h0000, 8'h00, 2'b01, 16'h0090, 8'hA5},
    '{PF, 16'hF000, 8'h00, 2'b00, 16'hF045, 8'hFF},
    '{PV, 16'h0000, 8'h00, 2'b00, 16'h0090, 8'hA5}
  };
  localparam logic [7:0] SA [3] = '{8'hF8, 8'hF9, 8'hFA};
  logic        clk, rst_n, sfr_we, pc_sec, rst_pin, pss_n, lps_n, ea_n;
  logic        done, oe, irq_n, hmode, o, in_app_update_mode;
  logic [1:0]  lock, lkc;
  logic [3:0]  cmd;
  logic [15:0] addr;
  logic [7:0]  sfr_a, sfr_wd, rdat, dout, din, v;
  int          n_mismatch, cmp_count, n, k;
  int          n_irq = 0, n_lkc = 0;

  host_model hm (.i_clk(clk), .i_done(done), .i_dout(dout), .i_oe(oe),
    .o_rst_pin(rst_pin), .o_pss_n(pss_n), .o_lps_n(lps_n),
    .o_ea_n(ea_n), .o_cmd(cmd), .o_addr(addr), .o_data(din));
  // Short burst timeout keeps the run brief
  flash_program_erase_controller #(.BURST_TO(40)) uut (
    .I_CLOCK(clk), .I_RESETN(rst_n), .i_RESET_PIN(rst_pin),
    .i_PROGRAM_STORE_STROBE_N(pss_n), .i_LATCH_PROGRAM_STROBE_N(lps_n),
    .i_EXTERNAL_ACCESS_N(ea_n), .i_CMD_PINS(cmd), .i_ADDR_PINS(addr),
    .i_DATA_PINS(din), .i_LOCK(lock), .i_SFR_WE(sfr_we),
    .i_SFR_ADDR(sfr_a), .i_SFR_WDATA(sfr_wd), .i_PC_IN_SEC(pc_sec),
    .o_SFR_RDATA(rdat), .o_DATA_PINS(dout), .o_DATA_OE(oe),
    .o_DONE_FLAG(done), .o_EXT_IRQ1_N(irq_n), .o_HOST_MODE(hmode),
    .o_IN_APP_UPDATE_MODE(in_app_update_mode), .o_LOCK_CLEARED(lkc));

  // Both pulses last one cycle; sampled mid-cycle so each counts once
  always @(negedge clk) begin
    if (irq_n === 1'b0) n_irq++;
    if (lkc === 2'b11) n_lkc++;
  end

  // ========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_a  = a;
    sfr_wd = d;
    sfr_we = 1'b1;
    @(negedge clk);
    sfr_we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_a = a;
    @(negedge clk);
    d = rdat;
  endtask
  task automatic wait_idle(output int c);
    logic [7:0] s;
    c = 0;
    do begin
      rd(flash_ctl_pkg::CFG_OFF, s);
      c++;
    end while (s[flash_ctl_pkg::CFG_BUSY_BIT] && c < 2000);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ========================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Chip erase alone takes some 66000 cycles
  initial begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  // ========================================
  // Main sequence
  initial begin
    n_mismatch = 0;
    cmp_count  = 0;
    rst_n  = 1'b0;
    lock   = 2'b00;
    sfr_we = 1'b0;
    sfr_a  = 8'h00;
    sfr_wd = 8'h00;
    pc_sec = 1'b1;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("done_rst", 8'(done), 8'h01);
    chk("oe_rst", 8'(oe), 8'h00);
    chk("irq_rst", 8'(irq_n), 8'h01);
    chk("host_rst", 8'(hmode), 8'h00);
    rd(flash_ctl_pkg::ADRL_OFF, v);
    chk("adrl_rst", v, flash_ctl_pkg::RESET_VAL);
    foreach (SA[i]) begin
      wr(SA[i], 8'(8'hA0 + i));
      rd(SA[i], v);
      chk("mailbox", v, 8'(8'hA0 + i));
    end
    rd(8'h80, v);
    chk("unmapped", v, 8'h00);
    lock = 2'b01;
    rd(flash_ctl_pkg::CFG_OFF, v);
    chk("cfg_status", {6'h00, v[7:6]}, 8'h03);
    lock = 2'b00;
    $display("test reset_regs done");
    // In-application sector erase at prescale 1, interrupt enabled
    wr(flash_ctl_pkg::CFG_OFF, 8'h01);
    wr(flash_ctl_pkg::ADRH_OFF, 8'hF0);
    wr(flash_ctl_pkg::ADRL_OFF, 8'h40);
    wr(flash_ctl_pkg::CMD_OFF, 8'h8B);
    chk("iap_mode", 8'(in_app_update_mode), 8'h01);
    wait_idle(k);
    // 64 bytes plus 2 x 512 cycles, two cycles per status read
    chk("erase_len", 8'(k > 520 && k < 570), 8'h01);
    chk("irq_count", 8'(n_irq), 8'h01);
    wr(flash_ctl_pkg::CFG_OFF, 8'h00);
    wr(flash_ctl_pkg::ADRL_OFF, 8'h50);
    wr(flash_ctl_pkg::DATA_OFF, 8'h96);
    wr(flash_ctl_pkg::CMD_OFF, 8'h0E);
    wait_idle(k);
    wr(flash_ctl_pkg::CMD_OFF, 8'h0C);
    rd(flash_ctl_pkg::DATA_OFF, v);
    chk("iap_verify", v, 8'h96);
    lock = 2'b10;
    wr(flash_ctl_pkg::ADRL_OFF, 8'h60);
    wr(flash_ctl_pkg::CMD_OFF, 8'h0E);
    lock = 2'b00;
    wr(flash_ctl_pkg::CMD_OFF, 8'h0C);
    rd(flash_ctl_pkg::DATA_OFF, v);
    chk("iap_locked", v, flash_ctl_pkg::ERASED);
    wr(flash_ctl_pkg::CMD_OFF, 8'h00);
    chk("iap_exit", 8'(in_app_update_mode), 8'h00);
    chk("irq_once", 8'(n_irq), 8'h01);
    $display("test in_app done");
    hm.enter();
    chk("host_mode", 8'(hmode), 8'h01);
    lock = 2'b11;
    hm.pulse(flash_ctl_pkg::H_CHIP, 16'h0000, 8'h00, 1'b1, n);
    lock = 2'b00;
    hm.verify(16'h0010, v, o);
    chk("chip_erase", v, flash_ctl_pkg::ERASED);
    chk("lock_cleared", 8'(n_lkc), 8'h01);
    $display("test chip_erase done");
    foreach (ROWS[i]) begin
      lock = ROWS[i].l;
      if (ROWS[i].c != PV) hm.pulse(ROWS[i].c, ROWS[i].a, ROWS[i].d, 1'b1, n);
      lock = 2'b00;
      hm.verify(ROWS[i].va, v, o);
      chk("row_data", v, ROWS[i].e);
      chk("row_oe", 8'(o), 8'h01);
      if (i == 0) chk("busy_len", 8'(n > 55 && n < 68), 8'h01);
    end
    $display("test rows done");
    lock = 2'b01;
    hm.verify(16'h0090, v, o);
    chk("oe_locked", 8'(o), 8'h00);
    lock = 2'b00;
    hm.pulse(PB, 16'h0200, 8'h80, 1'b0, n);
    hm.verify(16'h0200, v, o);
    chk("poll_busy", 8'(v[7]), 8'h00);
    for (k = 0; k < 200 && done !== 1'b1; k++) @(negedge clk);
    hm.verify(16'h0200, v, o);
    chk("poll_done", 8'(v[7]), 8'h01);
    $display("test polling done");
    hm.pulse(PB, 16'h0300, 8'h12, 1'b0, n);
    hm.pulse(PB, 16'h0301, 8'h34, 1'b1, n);
    hm.verify(16'h0301, v, o);
    chk("busy_refuse", v, 8'hFF);
    hm.verify(16'h0300, v, o);
    chk("busy_first", v, 8'h12);
    $display("test busy done");
    hm.pulse(PK, 16'h0400, 8'h01, 1'b1, n);
    chk("burst_ready", 8'(done), 8'h01);
    hm.pulse(PK, 16'h0401, 8'h02, 1'b1, n);
    hm.pulse(PB, 16'h0480, 8'h03, 1'b1, n);
    for (k = 0; k < 2; k++) begin
      hm.verify(16'h0400 + 16'(k), v, o);
      chk("burst_data", v, 8'(k + 1));
    end
    hm.verify(16'h0402, v, o);
    chk("burst_gap", v, flash_ctl_pkg::ERASED);
    hm.verify(16'h0480, v, o);
    chk("burst_end", v, 8'h03);
    $display("test burst done");
    close_out();
  end
endmodule // tb
